//--- inc/pil_pkg.sv
// constants for the configurable parallel input lines block
package pil_pkg;

  // ------------------------------------------------------------
  // line map
  // ------------------------------------------------------------
  localparam int unsigned NUM_LINES = 28;
  localparam int unsigned IDX_W     = 5;
  localparam logic [4:0]  KEY_BASE  = 5'h00; // control-key port, lines 0..7
  localparam logic [4:0]  EXT_BASE  = 5'h08; // auxiliary inputs 0..7
  localparam logic [4:0]  INT_BASE  = 5'h10; // auxiliary 8..15 and additional 0..3
  localparam logic [4:0]  LAST_LINE = 5'h1B;

  // ------------------------------------------------------------
  // per-line configuration word layout
  // ------------------------------------------------------------
  localparam int unsigned CFG_EN_BIT   = 0;
  localparam int unsigned CFG_POL_BIT  = 1;  // 1 = active high
  localparam int unsigned CFG_MODE_LSB = 4;  // 3 bits
  localparam int unsigned CFG_CODE_LSB = 8;  // 4 bits, remote_report_code
  localparam int unsigned CFG_EQP_LSB  = 12; // 4 bits, equipment_identifier
  localparam int unsigned CFG_COL_LSB  = 16; // 4 bits, panel_column_identifier
  localparam int unsigned CFG_TYPE_LSB = 20; // 2 bits
  localparam int unsigned CFG_DESC_LSB = 24; // 8 bits, history description handle
  localparam logic [31:0] CFG_RST      = 32'h0000_0000;

  // functional modes
  localparam logic [2:0] MODE_AUX   = 3'h0;
  localparam logic [2:0] MODE_CMD   = 3'h1;
  localparam logic [2:0] MODE_LAMP  = 3'h2;
  localparam logic [2:0] MODE_BUZZ  = 3'h3;
  localparam logic [2:0] MODE_SEL   = 3'h4;
  localparam logic [2:0] MODE_PARAL = 3'h5;

  // signal types
  localparam logic [1:0] TYPE_PNL = 2'h0;
  localparam logic [1:0] TYPE_EXT = 2'h1;
  localparam logic [1:0] TYPE_ENV = 2'h2;

  // command key codes
  localparam logic [3:0] KEY_REQ_REL   = 4'h0;
  localparam logic [3:0] KEY_ON_OFF    = 4'h1;
  localparam logic [3:0] KEY_CHANGEOVR = 4'h2;

  localparam logic [3:0] EQP_OWN    = 4'h1;
  localparam logic [3:0] COL_OWN    = 4'h1;
  localparam int unsigned NUM_FAULT = 12;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [11:0] REG_LINE_STATE = 12'h000;
  localparam logic [11:0] REG_ENV_LED    = 12'h004;
  localparam logic [11:0] REG_CTRL       = 12'h008;
  localparam logic [11:0] REG_EVT_COUNT  = 12'h00C;
  localparam logic [11:0] REG_FAULT      = 12'h010;
  localparam logic [11:0] REG_CFG_BASE   = 12'h080;
  localparam logic [11:0] REG_CFG_LAST   = 12'h0EC;
  localparam logic [0:0]  CTRL_RST       = 1'h1;

endpackage : pil_pkg

//--- core/pil_cfg_mem.sv
// per-line configuration store, one write port and two registered read ports

module pil_cfg_mem (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // write port
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_addr,
  input  wire logic [31:0] wr_data,
  // read ports
  input  wire logic [4:0]  rd_a_addr,
  output logic      [31:0] rd_a_data,
  input  wire logic [4:0]  rd_b_addr,
  output logic      [31:0] rd_b_data
);

  logic [31:0] mem_ff     [pil_pkg::NUM_LINES];
  logic [31:0] nxt_mem    [pil_pkg::NUM_LINES];
  logic [31:0] nxt_rd_a;
  logic [31:0] nxt_rd_b;

  always_comb begin
    nxt_mem = mem_ff;
    if (wr_en && wr_addr <= pil_pkg::LAST_LINE) begin
      nxt_mem[wr_addr] = wr_data;
    end
    nxt_rd_a = (rd_a_addr <= pil_pkg::LAST_LINE) ? mem_ff[rd_a_addr] : 32'h0000_0000;
    nxt_rd_b = (rd_b_addr <= pil_pkg::LAST_LINE) ? mem_ff[rd_b_addr] : 32'h0000_0000;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < pil_pkg::NUM_LINES; i++) begin
        mem_ff[i] <= pil_pkg::CFG_RST;
      end
      rd_a_data <= 32'h0000_0000;
      rd_b_data <= 32'h0000_0000;
    end else begin
      mem_ff    <= nxt_mem;
      rd_a_data <= nxt_rd_a;
      rd_b_data <= nxt_rd_b;
    end
  end

endmodule : pil_cfg_mem

//--- core/pil_input_lines.sv
// configurable parallel input lines: sampling, polarity, change events, panel actions, APB slave
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.

// What this block does
// RL1: each line is read through its own active-low or active-high polarity, configurable on auxiliary lines 0..7 (lines 8..15) only.
// RL2: control-key lines are always active-low, internal power lines always active-high.
// RL3: auxiliary external lines accept either polarity, active-high being usual.
// RL4: with active-high polarity an open wire reads as the alarm state.
// RL5: each line carries report code 0..15, sent to remote users on change.
// RL6: each line carries a type: panel key, external command or environmental alarm.
// RL7: a status change records the line's description handle in the history log.
// RL8: disabled lines give no events, no reports and no history entries.
// RL9: auxiliary-mode lines report the status of external alarm sources.
// RL10: environmental alarm lines light their panel LED while in alarm.
// RL11: command lines decode key 0 request/release, 1 on/off, 2 changeover.
// RL12: command lines act only for equipment identifier 1.
// RL13: lamp-test mode marks the panel lamp-test key, no further parameters.
// RL14: buzzer-silence mode silences the buzzer for equipment identifier 1.
// RL15: selection mode toggles the detailed section for panel column 1.
// RL16: parallel internal mode handles twelve mains and battery module signals.
// RL17: four input ports: keys, auxiliary 0..7, auxiliary 8..15, additional 0..3.
// RL18: internal report codes 0..11 identify the power fault sources.
// RL19: enabled lines are sampled and compared with stored state; difference raises an event.
module pil_input_lines (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // input ports
  input  wire logic [7:0]  key_in,
  input  wire logic [7:0]  aux_lo_in,
  input  wire logic [7:0]  aux_hi_in,
  input  wire logic [3:0]  addl_in,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // change report and history log
  output logic             evt_valid,
  output logic      [4:0]  evt_line,
  output logic      [3:0]  evt_code,
  output logic             evt_state,
  output logic      [1:0]  evt_type,
  output logic             log_valid,
  output logic      [7:0]  log_descr,
  // panel actions
  output logic             cmd_valid,
  output logic      [1:0]  cmd_key,
  output logic             lamp_test,
  output logic             buzz_silence,
  output logic             detail_enable,
  output logic      [27:0] env_led,
  output logic      [11:0] power_fault
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic is_cfg_addr(input logic [11:0] a);
    return (a >= pil_pkg::REG_CFG_BASE) && (a <= pil_pkg::REG_CFG_LAST) && (a[1:0] == 2'h0);
  endfunction : is_cfg_addr
  function automatic logic [4:0] cfg_index(input logic [11:0] a);
    logic [11:0] d;
    d = a - pil_pkg::REG_CFG_BASE;
    return d[6:2];
  endfunction : cfg_index

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [27:0] sync1_ff;
  logic [27:0] sync2_ff;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_ff <= 28'h0000000;
      sync2_ff <= 28'h0000000;
    end else begin
      sync1_ff <= {addl_in, aux_hi_in, aux_lo_in, key_in}; // RL17
      sync2_ff <= sync1_ff;
    end
  end

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  logic [31:0] cfg_rd_a;
  logic [31:0] cfg_rd_b;
  logic        ctrl_scan_ff;
  logic [15:0] evt_count_ff;
  logic [27:0] state_ff;
  logic [31:0] nxt_prdata;
  logic        nxt_pready;
  logic        nxt_pslverr;
  logic        nxt_ctrl_scan;
  logic        mem_wr;
  logic        acc_done;
  logic        mapped;
  assign acc_done = psel && penable && pready;
  always_comb begin
    mapped        = is_cfg_addr(paddr) || paddr == pil_pkg::REG_LINE_STATE || paddr == pil_pkg::REG_ENV_LED
                    || paddr == pil_pkg::REG_CTRL || paddr == pil_pkg::REG_EVT_COUNT || paddr == pil_pkg::REG_FAULT;
    nxt_pready    = psel && penable && !pready;
    nxt_pslverr   = psel && penable && !pready && !mapped;
    nxt_prdata    = 32'h0000_0000;
    nxt_ctrl_scan = ctrl_scan_ff;
    mem_wr        = acc_done && pwrite && is_cfg_addr(paddr);
    if (psel && penable && !pready && !pwrite) begin
      if (is_cfg_addr(paddr)) begin
        nxt_prdata = cfg_rd_a;
      end else begin
        unique case (paddr)
          pil_pkg::REG_LINE_STATE: nxt_prdata = {4'h0, state_ff};
          pil_pkg::REG_ENV_LED:    nxt_prdata = {4'h0, env_led};
          pil_pkg::REG_CTRL:       nxt_prdata = {31'h0, ctrl_scan_ff};
          pil_pkg::REG_EVT_COUNT:  nxt_prdata = {16'h0000, evt_count_ff};
          pil_pkg::REG_FAULT:      nxt_prdata = {20'h00000, power_fault};
          default:                 nxt_prdata = 32'h0000_0000;
        endcase
      end
    end
    if (acc_done && pwrite && paddr == pil_pkg::REG_CTRL) begin
      nxt_ctrl_scan = pwdata[0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata       <= 32'h0000_0000;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      ctrl_scan_ff <= pil_pkg::CTRL_RST;
    end else begin
      prdata       <= nxt_prdata;
      pready       <= nxt_pready;
      pslverr      <= nxt_pslverr;
      ctrl_scan_ff <= nxt_ctrl_scan;
    end
  end

  // ------------------------------------------------------------
  // configuration store and scan pipeline
  // ------------------------------------------------------------
  logic [4:0] scan_idx_ff;
  logic [4:0] eval_idx_ff;
  logic       eval_vld_ff;
  logic [4:0] nxt_scan_idx;
  pil_cfg_mem u_cfg_mem (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .wr_en     (mem_wr),
    .wr_addr   (cfg_index(paddr)),
    .wr_data   (pwdata),
    .rd_a_addr (cfg_index(paddr)),
    .rd_a_data (cfg_rd_a),
    .rd_b_addr (scan_idx_ff),
    .rd_b_data (cfg_rd_b)
  );
  assign nxt_scan_idx = (scan_idx_ff == pil_pkg::LAST_LINE) ? 5'h00 : scan_idx_ff + 5'h01;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scan_idx_ff <= 5'h00;
      eval_idx_ff <= 5'h00;
      eval_vld_ff <= 1'b0;
    end else begin
      scan_idx_ff <= ctrl_scan_ff ? nxt_scan_idx : scan_idx_ff;
      eval_idx_ff <= scan_idx_ff;
      eval_vld_ff <= ctrl_scan_ff;
    end
  end

  // ------------------------------------------------------------
  // line evaluation
  // ------------------------------------------------------------
  logic       c_en;
  logic       c_pol_high;
  logic [2:0] c_mode;
  logic [3:0] c_code;
  logic [3:0] c_eqp;
  logic [3:0] c_col;
  logic [1:0] c_type;
  logic       raw;
  logic       cur;
  logic       change;
  logic       press;
  always_comb begin
    c_en   = cfg_rd_b[pil_pkg::CFG_EN_BIT];
    c_mode = cfg_rd_b[pil_pkg::CFG_MODE_LSB +: 3];
    c_code = cfg_rd_b[pil_pkg::CFG_CODE_LSB +: 4];
    c_eqp  = cfg_rd_b[pil_pkg::CFG_EQP_LSB +: 4];
    c_col  = cfg_rd_b[pil_pkg::CFG_COL_LSB +: 4];
    c_type = cfg_rd_b[pil_pkg::CFG_TYPE_LSB +: 2];
    raw    = sync2_ff[eval_idx_ff];
    if (eval_idx_ff < pil_pkg::EXT_BASE) begin
      c_pol_high = 1'b0; // RL2
    end else if (eval_idx_ff >= pil_pkg::INT_BASE) begin
      c_pol_high = 1'b1; // RL2
    end else begin
      c_pol_high = cfg_rd_b[pil_pkg::CFG_POL_BIT]; // RL3
    end
    // active high: a pulled-up open wire reads as alarm
    cur    = c_pol_high ? raw : !raw; // RL1 RL4
    change = eval_vld_ff && c_en && (cur != state_ff[eval_idx_ff]); // RL19 RL8
    press  = change && cur;
  end

  // ------------------------------------------------------------
  // events and panel actions
  // ------------------------------------------------------------
  logic [27:0] nxt_state;
  logic [27:0] nxt_env_led;
  logic [11:0] nxt_fault;
  logic [15:0] nxt_evt_count;
  logic        nxt_lamp;
  logic        nxt_detail;
  logic        nxt_cmd_valid;
  logic        nxt_buzz;
  always_comb begin
    nxt_state     = state_ff;
    nxt_env_led   = env_led;
    nxt_fault     = power_fault;
    nxt_evt_count = evt_count_ff;
    nxt_lamp      = lamp_test;
    nxt_detail    = detail_enable;
    nxt_cmd_valid = press && c_mode == pil_pkg::MODE_CMD && c_eqp == pil_pkg::EQP_OWN
                    && c_code <= pil_pkg::KEY_CHANGEOVR; // RL11 RL12
    nxt_buzz      = press && c_mode == pil_pkg::MODE_BUZZ && c_eqp == pil_pkg::EQP_OWN; // RL14
    if (eval_vld_ff) begin
      if (!c_en) begin
        nxt_state[eval_idx_ff]   = 1'b0; // RL8
        nxt_env_led[eval_idx_ff] = 1'b0;
      end else begin
        nxt_state[eval_idx_ff]   = cur; // RL19
        nxt_env_led[eval_idx_ff] = cur && c_mode == pil_pkg::MODE_AUX && c_type == pil_pkg::TYPE_ENV; // RL9 RL10
        if (c_mode == pil_pkg::MODE_LAMP) begin
          nxt_lamp = cur; // RL13
        end
        if (c_mode == pil_pkg::MODE_PARAL && c_code < 4'(pil_pkg::NUM_FAULT)) begin
          nxt_fault[c_code] = cur; // RL16 RL18
        end
        if (press && c_mode == pil_pkg::MODE_SEL && c_col == pil_pkg::COL_OWN) begin
          nxt_detail = !detail_enable; // RL15
        end
      end
      if (change) begin
        nxt_evt_count = evt_count_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff      <= 28'h0000000;
      env_led       <= 28'h0000000;
      power_fault   <= 12'h000;
      evt_count_ff  <= 16'h0000;
      lamp_test     <= 1'b0;
      detail_enable <= 1'b0;
      cmd_valid     <= 1'b0;
      cmd_key       <= 2'h0;
      buzz_silence  <= 1'b0;
      evt_valid     <= 1'b0;
      evt_line      <= 5'h00;
      evt_code      <= 4'h0;
      evt_state     <= 1'b0;
      evt_type      <= 2'h0;
      log_valid     <= 1'b0;
      log_descr     <= 8'h00;
    end else begin
      state_ff      <= nxt_state;
      env_led       <= nxt_env_led;
      power_fault   <= nxt_fault;
      evt_count_ff  <= nxt_evt_count;
      lamp_test     <= nxt_lamp;
      detail_enable <= nxt_detail;
      cmd_valid     <= nxt_cmd_valid;
      cmd_key       <= nxt_cmd_valid ? c_code[1:0] : cmd_key;
      buzz_silence  <= nxt_buzz;
      evt_valid     <= change; // RL5
      evt_line      <= change ? eval_idx_ff : evt_line;
      evt_code      <= change ? c_code : evt_code; // RL5
      evt_state     <= change ? cur : evt_state;
      evt_type      <= change ? c_type : evt_type; // RL6
      log_valid     <= change; // RL7
      log_descr     <= change ? cfg_rd_b[pil_pkg::CFG_DESC_LSB +: 8] : log_descr; // RL7
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_DISABLED_SILENT: assert property (eval_vld_ff && !c_en |=> !evt_valid && !log_valid) // RL8
    else $error("disabled line produced an event");
  AST_CHANGE_EVENT: assert property (change |=> evt_valid && evt_line == $past(eval_idx_ff) // RL19
                                     && evt_state == $past(cur))
    else $error("change did not raise matching event");
  AST_REPORT_CODE: assert property (change |=> evt_code == $past(c_code) && evt_type == $past(c_type)) // RL5
    else $error("event code or type mismatch");
  AST_KEY_LOW: assert property (eval_vld_ff && eval_idx_ff < 5'h08 |-> cur == !raw) // RL2
    else $error("control key not active low");
  AST_INT_HIGH: assert property (eval_vld_ff && eval_idx_ff >= 5'h10 |-> cur == raw) // RL2
    else $error("internal line not active high");
  AST_AUX_POL: assert property (eval_vld_ff && eval_idx_ff inside {[5'h08:5'h0F]} // RL1
                                |-> cur == (cfg_rd_b[1] ? raw : !raw))
    else $error("auxiliary polarity wrong");
  AST_LOG_PAIR: assert property (evt_valid |-> log_valid && log_descr == $past(cfg_rd_b[31:24])) // RL7
    else $error("history entry missing");
  AST_CMD_KEY: assert property (press && c_mode == 3'h1 && c_eqp == 4'h1 && c_code < 4'h3 // RL11
                                |=> cmd_valid && cmd_key == $past(c_code[1:0]))
    else $error("command key not decoded");
  AST_CMD_EQP: assert property (cmd_valid |-> $past(c_eqp) == 4'h1) // RL12
    else $error("command for foreign equipment");
  AST_ENV_LED: assert property (eval_vld_ff && c_en && c_mode == 3'h0 && c_type == 2'h2 // RL10
                                |=> env_led[$past(eval_idx_ff)] == $past(cur))
    else $error("environment LED does not follow alarm");
  AST_BUZZ: assert property (buzz_silence |-> $past(c_mode) == 3'h3 && $past(c_eqp) == 4'h1) // RL14
    else $error("buzzer silence without key");
  AST_SELECT: assert property (press && c_mode == 3'h4 && c_col == 4'h1 // RL15
                               |=> detail_enable != $past(detail_enable))
    else $error("select key did not toggle detail");
  AST_FAULT: assert property (eval_vld_ff && c_en && c_mode == 3'h5 && c_code < 4'hC // RL16
                              |=> power_fault[$past(c_code)] == $past(cur))
    else $error("power fault bit not updated");
  AST_LAMP: assert property (eval_vld_ff && c_en && c_mode == 3'h2 |=> lamp_test == $past(cur)) // RL13
    else $error("lamp test not following key");
  AST_APB_WAIT: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  COV_EVENT: cover property (change ##1 evt_valid);
  COV_CMD: cover property (cmd_valid);
  COV_ENV: cover property (|env_led);
  COV_CFG_WRITE: cover property (mem_wr);

endmodule : pil_input_lines

//--- testbench/pil_line_src.sv
// far-side model: panel keys, external alarm contacts and power module fail lines
module pil_line_src (
  // bench stimulus
  input  wire logic [7:0]  key_press,
  input  wire logic [7:0]  aux_lvl,
  input  wire logic [7:0]  aux_open,
  input  wire logic [11:0] pwr_fail,
  // pins toward the block
  output logic      [7:0]  key_in,
  output logic      [7:0]  aux_lo_in,
  output logic      [7:0]  aux_hi_in,
  output logic      [3:0]  addl_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // a pressed key pulls its line low
  assign key_in    = ~key_press;
  // an open contact floats up through its pull-up
  assign aux_lo_in = aux_lvl | aux_open;
  // module fail lines drive high on fault
  assign aux_hi_in = pwr_fail[7:0];
  assign addl_in   = pwr_fail[11:8];
endmodule : pil_line_src

//--- testbench/tb.sv
// self-checking bench for the parallel input lines block
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, err_seen;
  logic [11:0] paddr, pwr_fail, power_fault;
  logic [31:0] pwdata, prdata, rd;
  logic        evt_valid, evt_state, log_valid, cmd_valid, lamp_test, buzz_silence, detail_enable;
  logic [4:0]  evt_line;
  logic [3:0]  evt_code, addl_in;
  logic [1:0]  evt_type, cmd_key, cmd_snap;
  logic [7:0]  log_descr, key_in, aux_lo_in, aux_hi_in, key_press, aux_lvl, aux_open;
  logic [27:0] env_led;
  logic [19:0] ev_snap;
  int          errors, checked, ev_cnt, cmd_cnt, buzz_cnt, i, n;

  pil_line_src u_src (.key_press(key_press), .aux_lvl(aux_lvl), .aux_open(aux_open), .pwr_fail(pwr_fail),
    .key_in(key_in), .aux_lo_in(aux_lo_in), .aux_hi_in(aux_hi_in), .addl_in(addl_in));
  pil_input_lines u_dut (.clk(clk), .sys_rst(sys_rst), .key_in(key_in), .aux_lo_in(aux_lo_in),
    .aux_hi_in(aux_hi_in), .addl_in(addl_in), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .evt_valid(evt_valid), .evt_line(evt_line), .evt_code(evt_code), .evt_state(evt_state),
    .evt_type(evt_type), .log_valid(log_valid), .log_descr(log_descr), .cmd_valid(cmd_valid),
    .cmd_key(cmd_key), .lamp_test(lamp_test), .buzz_silence(buzz_silence),
    .detail_enable(detail_enable), .env_led(env_led), .power_fault(power_fault));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    rd = prdata;
    err_seen = pslverr;
    if (k >= 100) check(32'h0, 32'h1, "apb no answer");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic ex_err, input string m);
    apb(1'b0, a, 32'h0);
    check(rd, exp, m);
    check(32'(err_seen), 32'(ex_err), m);
  endtask : rdc

  task automatic setcfg(input int idx, input logic [31:0] w);
    apb(1'b1, pil_pkg::REG_CFG_BASE + 12'(4 * idx), w);
  endtask : setcfg

  function automatic logic [31:0] cfg(input logic pol, input logic [2:0] md, input logic [3:0] cd,
                                      input logic [3:0] eq, input logic [3:0] col, input logic [1:0] ty,
                                      input logic [7:0] ds);
    return {ds, 2'h0, ty, col, eq, cd, 1'b0, md, 2'h0, pol, 1'b1};
  endfunction : cfg

  // pin change to event is bounded by sync plus one scan round
  task automatic key(input int idx, input logic v);
    key_press[idx] <= v;
    repeat (40) @(posedge clk);
  endtask : key

  task automatic settle;
    repeat (40) @(posedge clk);
  endtask : settle

  task automatic finish_test;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  // ------------------------------------------------------------
  // clock, monitor, watchdog
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (evt_valid === 1'b1) begin
      ev_cnt++;
      ev_snap = {evt_line, evt_code, evt_state, evt_type, log_descr};
      check(32'(log_valid), 32'h1, "log pulse with event");
    end
    if (cmd_valid === 1'b1) begin
      cmd_cnt++;
      cmd_snap = cmd_key;
    end
    if (buzz_silence === 1'b1) buzz_cnt++;
  end

  initial begin
    repeat (20000) @(posedge clk);
    check(32'h0, 32'h1, "watchdog expired");
    finish_test();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = '0;
    sys_rst = 1'b1;
    {key_press, aux_lvl, aux_open, pwr_fail} = '0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(pil_pkg::REG_CTRL, 32'h1, 1'b0, "ctrl reset");
    rdc(pil_pkg::REG_EVT_COUNT, 32'h0, 1'b0, "count reset");
    rdc(pil_pkg::REG_CFG_BASE, pil_pkg::CFG_RST, 1'b0, "cfg reset");
    rdc(12'h040, 32'h0, 1'b1, "unmapped read");
    apb(1'b1, pil_pkg::REG_LINE_STATE, 32'hFFFF_FFFF);
    rdc(pil_pkg::REG_LINE_STATE, 32'h0, 1'b0, "read-only write");
    // open wire on an active-high auxiliary line
    aux_open[0] <= 1'b1;
    setcfg(8, cfg(1'b1, pil_pkg::MODE_AUX, 4'h5, 4'h0, 4'h0, pil_pkg::TYPE_ENV, 8'hA5));
    settle();
    check(32'(ev_snap), {12'h0, 5'h08, 4'h5, 1'b1, pil_pkg::TYPE_ENV, 8'hA5}, "open wire alarm");
    check(32'(env_led), 32'h100, "env led lit");
    rdc(pil_pkg::REG_ENV_LED, 32'h100, 1'b0, "env led register");
    aux_open[0] <= 1'b0;
    settle();
    check(32'(ev_snap), {12'h0, 5'h08, 4'h5, 1'b0, pil_pkg::TYPE_ENV, 8'hA5}, "contact closed");
    check(32'(env_led), 32'h0, "env led off");
    // active-low auxiliary line enabled while its pin is low
    setcfg(9, cfg(1'b0, pil_pkg::MODE_AUX, 4'hF, 4'h0, 4'h0, pil_pkg::TYPE_EXT, 8'h5A));
    settle();
    check(32'(ev_snap), {12'h0, 5'h09, 4'hF, 1'b1, pil_pkg::TYPE_EXT, 8'h5A}, "active low line");
    check(32'(env_led), 32'h0, "no led for ext type");
    rdc(pil_pkg::REG_LINE_STATE, 32'h200, 1'b0, "line state");
    apb(1'b1, pil_pkg::REG_CFG_BASE + 12'h024, 32'h0);
    settle();
    rdc(pil_pkg::REG_LINE_STATE, 32'h0, 1'b0, "disabled state");
    n = ev_cnt;
    aux_lvl[2] <= 1'b1;
    settle();
    aux_lvl[2] <= 1'b0;
    settle();
    check(32'(ev_cnt), 32'(n), "disabled line quiet");
    // command keys, polarity bit set to show keys stay active low
    for (i = 0; i < 3; i++) setcfg(i, cfg(1'b1, pil_pkg::MODE_CMD, 4'(i), pil_pkg::EQP_OWN, 4'h0,
                                         pil_pkg::TYPE_PNL, 8'(i)));
    for (i = 0; i < 3; i++) begin
      n = cmd_cnt;
      key(i, 1'b1);
      check(32'(cmd_cnt), 32'(n + 1), "command on press");
      check(32'(cmd_snap), 32'(i), "command key code");
      key(i, 1'b0);
      check(32'(cmd_cnt), 32'(n + 1), "no command on release");
    end
    setcfg(6, cfg(1'b0, pil_pkg::MODE_CMD, pil_pkg::KEY_ON_OFF, 4'h2, 4'h0, pil_pkg::TYPE_PNL, 8'h0));
    n = cmd_cnt;
    key(6, 1'b1);
    key(6, 1'b0);
    check(32'(cmd_cnt), 32'(n), "foreign equipment ignored");
    setcfg(7, cfg(1'b0, pil_pkg::MODE_CMD, 4'h3, pil_pkg::EQP_OWN, 4'h0, pil_pkg::TYPE_PNL, 8'h0));
    key(7, 1'b1);
    key(7, 1'b0);
    check(32'(cmd_cnt), 32'(n), "undefined key code ignored");
    // lamp test, buzzer silence, selection
    setcfg(3, cfg(1'b0, pil_pkg::MODE_LAMP, 4'h0, 4'h0, 4'h0, pil_pkg::TYPE_PNL, 8'h0));
    key(3, 1'b1);
    check(32'(lamp_test), 32'h1, "lamp test held");
    key(3, 1'b0);
    check(32'(lamp_test), 32'h0, "lamp test released");
    setcfg(4, cfg(1'b0, pil_pkg::MODE_BUZZ, 4'h0, pil_pkg::EQP_OWN, 4'h0, pil_pkg::TYPE_PNL, 8'h0));
    n = buzz_cnt;
    key(4, 1'b1);
    key(4, 1'b0);
    check(32'(buzz_cnt), 32'(n + 1), "buzzer silenced once");
    setcfg(5, cfg(1'b0, pil_pkg::MODE_SEL, 4'h0, 4'h0, pil_pkg::COL_OWN, pil_pkg::TYPE_PNL, 8'h0));
    key(5, 1'b1);
    check(32'(detail_enable), 32'h1, "detail on");
    key(5, 1'b0);
    key(5, 1'b1);
    check(32'(detail_enable), 32'h0, "detail off");
    key(5, 1'b0);
    // stopped scan holds off events until it is enabled again
    apb(1'b1, pil_pkg::REG_CTRL, 32'h0);
    rdc(pil_pkg::REG_CTRL, 32'h0, 1'b0, "scan off");
    n = ev_cnt;
    key(0, 1'b1);
    check(32'(ev_cnt), 32'(n), "scan stopped");
    apb(1'b1, pil_pkg::REG_CTRL, 32'h1);
    settle();
    check(32'(ev_cnt), 32'(n + 1), "scan resumed");
    key(0, 1'b0);
    // internal power fail lines, polarity bit clear to show they stay active high
    setcfg(16, cfg(1'b0, pil_pkg::MODE_PARAL, 4'hA, pil_pkg::EQP_OWN, 4'h0, pil_pkg::TYPE_PNL, 8'h0));
    setcfg(24, cfg(1'b0, pil_pkg::MODE_PARAL, 4'h0, pil_pkg::EQP_OWN, 4'h0, pil_pkg::TYPE_PNL, 8'h0));
    pwr_fail <= 12'h101;
    settle();
    check(32'(power_fault), 32'h401, "power faults");
    rdc(pil_pkg::REG_FAULT, 32'h401, 1'b0, "fault register");
    rdc(pil_pkg::REG_EVT_COUNT, 32'(ev_cnt), 1'b0, "event count");
    finish_test();
  end
endmodule : tb
